// ---- inc/otit_pkg.sv ----
/*
 * constants for the three-tier interrupt tree: address map, register
 * offsets, field positions and reset values.
 * assumes a 13-bit byte-addressed host bus with 8-bit registers.
 */
`default_nettype none

package otit_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int unsigned NUM_PORTS  = 8;
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned ADDR_W     = 13;

	typedef logic [DATA_W-1:0] otit_byte_type;
	typedef logic [ADDR_W-1:0] otit_addr_type;

	// ------------------------------------------------------------
	// address map
	// ------------------------------------------------------------
	localparam otit_addr_type PORT_WINDOW_END  = 13'h01ff;
	localparam int unsigned   PORT_SEL_LSB     = 6;
	localparam otit_addr_type DEV_SUMMARY_ADDR = 13'h0200;
	localparam otit_addr_type DEV_ENABLE_ADDR  = 13'h0201;
	localparam otit_addr_type DEV_MODE_ADDR    = 13'h0202;

	// per-port offsets inside a 64-byte window
	localparam logic [5:0] OFF_SUMMARY   = 6'h00;
	localparam logic [5:0] OFF_SUM_MASK  = 6'h01;
	localparam logic [5:0] OFF_TX_ENABLE = 6'h28;
	localparam logic [5:0] OFF_RX_ENABLE = 6'h29;
	localparam logic [5:0] OFF_TX_FLAGS  = 6'h2c;
	localparam logic [5:0] OFF_RX_FLAGS  = 6'h2d;

	// ------------------------------------------------------------
	// fields
	// ------------------------------------------------------------
	localparam int unsigned SUM_RX_BIT     = 0;
	localparam int unsigned SUM_TX_BIT     = 1;
	localparam int unsigned SUM_FRAMER_BIT = 2;
	localparam int unsigned SUM_ONESEC_BIT = 3;
	localparam int unsigned MODE_IRQ_EN_BIT = 3;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam otit_byte_type RESET_FLAGS  = 8'h00;
	localparam otit_byte_type RESET_ENABLE = 8'h00;
	localparam otit_byte_type RESET_MODE   = 8'h00;
	localparam otit_byte_type READ_ZERO    = 8'h00;
endpackage : otit_pkg

`default_nettype wire

// ---- inc/otit_port_if.sv ----
/*
 * carrier between the tree top and one per-port tier block: register
 * strobes in, flag and summary state out.
 * assumes one clock domain; strobes are single-cycle.
 */
`default_nettype none

interface otit_port_if;
	otit_pkg::otit_byte_type wdata;
	logic                    wr_sum_mask;
	logic                    wr_tx_enable;
	logic                    wr_rx_enable;
	logic                    rd_summary;
	logic                    rd_tx_flags;
	logic                    rd_rx_flags;
	otit_pkg::otit_byte_type tx_flags;
	otit_pkg::otit_byte_type rx_flags;
	otit_pkg::otit_byte_type tx_enable;
	otit_pkg::otit_byte_type rx_enable;
	otit_pkg::otit_byte_type summary;
	otit_pkg::otit_byte_type sum_mask;
	logic                    active;

	modport ctrl (
		output wdata, wr_sum_mask, wr_tx_enable, wr_rx_enable,
		output rd_summary, rd_tx_flags, rd_rx_flags,
		input  tx_flags, rx_flags, tx_enable, rx_enable, summary, sum_mask, active
	);
	modport port (
		input  wdata, wr_sum_mask, wr_tx_enable, wr_rx_enable,
		input  rd_summary, rd_tx_flags, rd_rx_flags,
		output tx_flags, rx_flags, tx_enable, rx_enable, summary, sum_mask, active
	);
endinterface : otit_port_if

`default_nettype wire

// ---- src/otit_port.sv ----
/*
 * tier one and tier two of one port: sticky cell event flags, their
 * enables, the port summary with framer and one-second bits, its mask.
 * assumes event inputs synchronous to sys_clk, strobes from the top.
 */
`default_nettype none

module otit_port (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] tx_cell_events,
	input  wire logic [7:0] rx_cell_events,
	input  wire logic       framer_irq_in_n,
	input  wire logic       one_second_event,
	otit_port_if.port       bus
);
	otit_pkg::otit_byte_type next_tx_flags;
	otit_pkg::otit_byte_type next_rx_flags;
	logic                    framer_event;
	logic                    one_second_flag;
	logic                    next_framer;
	logic                    next_one_second;
	logic                    rx_cell_summary;
	logic                    tx_cell_summary;

	// ------------------------------------------------------------
	// tier one
	// ------------------------------------------------------------
	// read clears all bits except those set by an event in the read cycle
	assign next_tx_flags = (bus.rd_tx_flags ? otit_pkg::RESET_FLAGS : bus.tx_flags)
	                       | tx_cell_events;
	assign next_rx_flags = (bus.rd_rx_flags ? otit_pkg::RESET_FLAGS : bus.rx_flags)
	                       | rx_cell_events;

	// flags and enables
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			bus.tx_flags  <= otit_pkg::RESET_FLAGS;
			bus.rx_flags  <= otit_pkg::RESET_FLAGS;
			bus.tx_enable <= otit_pkg::RESET_ENABLE;
			bus.rx_enable <= otit_pkg::RESET_ENABLE;
		end else begin
			bus.tx_flags <= next_tx_flags;
			bus.rx_flags <= next_rx_flags;
			if (bus.wr_tx_enable) begin
				bus.tx_enable <= bus.wdata;
			end
			if (bus.wr_rx_enable) begin
				bus.rx_enable <= bus.wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// tier two
	// ------------------------------------------------------------
	// mask then or
	// follow tier one, no read clear
	assign rx_cell_summary = |(bus.rx_flags & bus.rx_enable);
	assign tx_cell_summary = |(bus.tx_flags & bus.tx_enable);

	assign next_framer     = (framer_event & ~bus.rd_summary) | ~framer_irq_in_n;
	assign next_one_second = (one_second_flag & ~bus.rd_summary) | one_second_event;

	// sticky framer and one-second bits; a held framer pin re-sets at once
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			framer_event    <= 1'b0;
			one_second_flag <= 1'b0;
			bus.sum_mask    <= otit_pkg::RESET_ENABLE;
		end else begin
			framer_event    <= next_framer;
			one_second_flag <= next_one_second;
			if (bus.wr_sum_mask) begin
				bus.sum_mask <= bus.wdata;
			end
		end
	end

	always_comb begin
		bus.summary = otit_pkg::READ_ZERO;
		bus.summary[otit_pkg::SUM_RX_BIT]     = rx_cell_summary;
		bus.summary[otit_pkg::SUM_TX_BIT]     = tx_cell_summary;
		bus.summary[otit_pkg::SUM_FRAMER_BIT] = framer_event;
		bus.summary[otit_pkg::SUM_ONESEC_BIT] = one_second_flag;
	end

	assign bus.active = |(bus.summary & bus.sum_mask);
endmodule : otit_port

`default_nettype wire

// ---- src/otit_tree.sv ----
/*
 * eight-port interrupt tree with its host register decode and the
 * gated active-low host interrupt pin.
 * assumes host bus signals synchronous to sys_clk, one access per
 * cycle in which host_cs_n and host_as_n are both low.
 * assumes the host services top-down and writes zero to reserved
 * bits; cell event inputs arrive already in the sys_clk domain.
 */
`default_nettype none

module otit_tree (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        host_cs_n,
	input  wire logic        host_as_n,
	input  wire logic        host_write,
	input  wire logic [12:0] host_address,
	input  wire logic [7:0]  host_data_in,
	output logic      [7:0]  host_data_out,
	output logic             host_data_oe_n,
	output logic             host_irq_n,
	input  wire logic [63:0] tx_cell_events,
	input  wire logic [63:0] rx_cell_events,
	input  wire logic [7:0]  framer_irq_in_n,
	input  wire logic        one_second_event
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// true when the address hits the given offset of any port window
	// shared by all six offsets of every port, so the offset test sits in one place
	function automatic logic hits_port_reg(input otit_pkg::otit_addr_type addr,
	                                       input logic [5:0] offset);
		hits_port_reg = (addr <= otit_pkg::PORT_WINDOW_END) && (addr[5:0] == offset);
	endfunction : hits_port_reg

	logic                    access;
	logic                    rd_access;
	logic                    wr_access;
	logic [2:0]              sel_port;
	otit_pkg::otit_byte_type port_summary_status;
	otit_pkg::otit_byte_type port_summary_enable;
	otit_pkg::otit_byte_type device_mode;
	otit_pkg::otit_byte_type port_rdata [otit_pkg::NUM_PORTS];
	otit_pkg::otit_byte_type next_rdata;
	logic                    next_irq_n;

	// named decode and pin wires
	logic                    in_port_window;
	logic                    hit_dev_summary;
	logic                    hit_dev_enable;
	logic                    hit_dev_mode;
	logic                    wr_dev_enable;
	logic                    wr_dev_mode;
	otit_pkg::otit_byte_type masked_ports;
	logic                    any_port_pending;
	logic                    pin_enabled;

	// full 13-bit decode, one access per strobe cycle
	assign access    = ~host_cs_n & ~host_as_n;
	assign rd_access = access & ~host_write;
	assign wr_access = access & host_write;
	assign sel_port  = host_address[otit_pkg::PORT_SEL_LSB +: 3];

	// window and device register hits; anything else reads zero
	assign in_port_window  = (host_address <= otit_pkg::PORT_WINDOW_END);
	assign hit_dev_summary = (host_address == otit_pkg::DEV_SUMMARY_ADDR);
	assign hit_dev_enable  = (host_address == otit_pkg::DEV_ENABLE_ADDR);
	assign hit_dev_mode    = (host_address == otit_pkg::DEV_MODE_ADDR);
	// framer windows are decoded nowhere: their chip selects live outside this block
	assign wr_dev_enable   = wr_access & hit_dev_enable;
	assign wr_dev_mode     = wr_access & hit_dev_mode;

	// ------------------------------------------------------------
	// per-port tiers
	// ------------------------------------------------------------
	// one carrier per port keeps the strobes and state of a port together
	// tiers one and two per port
	otit_port_if port_bus [otit_pkg::NUM_PORTS] ();

	genvar p;
	generate
		for (p = 0; p < otit_pkg::NUM_PORTS; p++) begin : g_port
			logic mine;
			logic hit_summary;
			logic hit_sum_mask;
			logic hit_tx_enable;
			logic hit_rx_enable;
			logic hit_tx_flags;
			logic hit_rx_flags;

			assign mine = in_port_window && (sel_port == 3'(p));

			// offset hits, shared by the strobes and the read mux
			assign hit_summary   = mine & hits_port_reg(host_address, otit_pkg::OFF_SUMMARY);
			assign hit_sum_mask  = mine & hits_port_reg(host_address, otit_pkg::OFF_SUM_MASK);
			assign hit_tx_enable = mine & hits_port_reg(host_address, otit_pkg::OFF_TX_ENABLE);
			assign hit_rx_enable = mine & hits_port_reg(host_address, otit_pkg::OFF_RX_ENABLE);
			assign hit_tx_flags  = mine & hits_port_reg(host_address, otit_pkg::OFF_TX_FLAGS);
			assign hit_rx_flags  = mine & hits_port_reg(host_address, otit_pkg::OFF_RX_FLAGS);

			// write strobes; only the addressed port ever sees one
			assign port_bus[p].wdata        = host_data_in;
			assign port_bus[p].wr_sum_mask  = wr_access & hit_sum_mask;
			assign port_bus[p].wr_tx_enable = wr_access & hit_tx_enable;
			assign port_bus[p].wr_rx_enable = wr_access & hit_rx_enable;

			// read strobes; a flag read clears, so a write there must not
			assign port_bus[p].rd_summary   = rd_access & hit_summary;
			assign port_bus[p].rd_tx_flags  = rd_access & hit_tx_flags;
			assign port_bus[p].rd_rx_flags  = rd_access & hit_rx_flags;

			assign port_rdata[p] =
				hit_summary   ? port_bus[p].summary   :
				hit_sum_mask  ? port_bus[p].sum_mask  :
				hit_tx_enable ? port_bus[p].tx_enable :
				hit_rx_enable ? port_bus[p].rx_enable :
				hit_tx_flags  ? port_bus[p].tx_flags  :
				hit_rx_flags  ? port_bus[p].rx_flags  :
				otit_pkg::READ_ZERO;

			assign port_summary_status[p] = port_bus[p].active;

			// event lanes are eight bits per port, in port order
			otit_port u_port (
				.sys_clk          (sys_clk),
				.reset_n          (reset_n),
				.tx_cell_events   (tx_cell_events[p*8 +: 8]),
				.rx_cell_events   (rx_cell_events[p*8 +: 8]),
				.framer_irq_in_n  (framer_irq_in_n[p]),
				.one_second_event (one_second_event),
				.bus              (port_bus[p])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// device registers
	// ------------------------------------------------------------
	// port summary status is pure logic, so it clears by itself
	// mode bits other than the pin enable are stored only, so readback holds
	// both control bytes read back as written
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			port_summary_enable <= otit_pkg::RESET_ENABLE;
			device_mode         <= otit_pkg::RESET_MODE;
		end else begin
			if (wr_dev_enable) begin
				port_summary_enable <= host_data_in;
			end
			if (wr_dev_mode) begin
				device_mode <= host_data_in;
			end
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	// reserved and framer windows read zero
	// port summary, port summary, flags
	// one flat mux: a read may follow a read on every cycle, no wait state
	assign next_rdata =
		in_port_window  ? port_rdata[sel_port] :
		hit_dev_summary ? port_summary_status :
		hit_dev_enable  ? port_summary_enable :
		hit_dev_mode    ? device_mode :
		otit_pkg::READ_ZERO;

	// ------------------------------------------------------------
	// host interrupt pin
	// ------------------------------------------------------------
	// masked port bits to pin
	assign masked_ports     = port_summary_status & port_summary_enable;
	assign any_port_pending = |masked_ports;

	// pin enable gates output
	// the pin stays high while disabled, yet all flags keep collecting
	assign pin_enabled      = device_mode[otit_pkg::MODE_IRQ_EN_BIT];
	assign next_irq_n       = ~(pin_enabled & any_port_pending);

	// read answer one cycle after the strobe; pin registered against glitches
	// data out keeps the last read value; writes leave it alone
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			host_data_out  <= otit_pkg::READ_ZERO;
			host_data_oe_n <= 1'b1;
			host_irq_n     <= 1'b1;
		end else begin
			host_data_oe_n <= ~rd_access;
			host_irq_n     <= next_irq_n;
			if (rd_access) begin
				host_data_out <= next_rdata;
			end
		end
	end
endmodule : otit_tree

`default_nettype wire

// ---- tb/otit_tree_monitor.sv ----
/* checker for the interrupt tree: bus answers, readback, pin gating.
   assumes it is bound to otit_tree and sees only the top ports. */
`default_nettype none
module otit_tree_monitor (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        host_cs_n,
	input wire logic        host_as_n,
	input wire logic        host_write,
	input wire logic [12:0] host_address,
	input wire logic [7:0]  host_data_in,
	input wire logic [7:0]  host_data_out,
	input wire logic        host_data_oe_n,
	input wire logic        host_irq_n,
	input wire logic [63:0] tx_cell_events,
	input wire logic [63:0] rx_cell_events,
	input wire logic [7:0]  framer_irq_in_n,
	input wire logic        one_second_event
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       rd, wr, flag_rd;
	logic [7:0] mode, port_en, pin_q;
	// ----------------------------------------
	// shadow of device control bytes
	// ----------------------------------------
	assign rd = !host_cs_n && !host_as_n && !host_write;
	assign wr = !host_cs_n && !host_as_n && host_write;
	assign flag_rd = rd && host_address < 13'h0200 && host_address[5:1] == 5'h16;
	// shadows let the pin gating be judged from the ports alone
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			mode    <= 8'h00;
			port_en <= 8'h00;
		end else if (wr && host_address == 13'h0202) begin
			mode <= host_data_in;
		end else if (wr && host_address == 13'h0201) begin
			port_en <= host_data_in;
		end
	end
	// framer pins one edge back, to judge what the summary latched
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pin_q <= 8'hff;
		end else begin
			pin_q <= framer_irq_in_n;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_read_drives_out: assert property (rd |=> !host_data_oe_n)
		else $error("drive enable missing after read");
	a_reserved_reads_zero: assert property (rd && host_address > 13'h0202 |=>
		host_data_out == 8'h00) else $error("reserved read not zero");
	a_summary_upper_zero: assert property (rd && host_address < 13'h0200 &&
		host_address[5:0] == 6'h00 |=> host_data_out[7:4] == 4'h0) else $error("summary upper");
	a_mode_read_back: assert property (rd && host_address == 13'h0202 |=>
		host_data_out == $past(mode)) else $error("mode readback");
	a_enable_read_back: assert property (rd && host_address == 13'h0201 |=>
		host_data_out == $past(port_en)) else $error("port enable readback");
	a_pin_gate_off: assert property (!mode[3] |=> host_irq_n)
		else $error("irq with pin disabled");
	a_irq_needs_enable: assert property (!host_irq_n |-> $past(port_en) != 8'h00)
		else $error("irq with all ports masked");
	a_flags_whole_clear: assert property (flag_rd && tx_cell_events == 64'h0 &&
		rx_cell_events == 64'h0 ##1 rd && $stable(host_address) |=> host_data_out == 8'h00)
		else $error("flags survive read");
	a_idle_no_drive: assert property (!rd |=> host_data_oe_n)
		else $error("drive enable without read");
	a_second_sets_summary: assert property (one_second_event ##1 (rd &&
		host_address < 13'h0200 && host_address[5:0] == 6'h00) |=> host_data_out[3])
		else $error("one-second bit missing");
	a_framer_sets_summary: assert property (rd && host_address < 13'h0200 &&
		host_address[5:0] == 6'h00 && !pin_q[host_address[8:6]] |=> host_data_out[2])
		else $error("framer bit missing");
endmodule : otit_tree_monitor
bind otit_tree otit_tree_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n),
	.host_cs_n(host_cs_n), .host_as_n(host_as_n), .host_write(host_write),
	.host_address(host_address), .host_data_in(host_data_in), .host_data_out(host_data_out),
	.host_data_oe_n(host_data_oe_n), .host_irq_n(host_irq_n), .tx_cell_events(tx_cell_events),
	.rx_cell_events(rx_cell_events), .framer_irq_in_n(framer_irq_in_n),
	.one_second_event(one_second_event));
`default_nettype wire

// ---- tb/otit_host.sv ----
/* host processor model: byte accesses on the register bus.
   assumes callers start at a falling edge and end with idle. */
`default_nettype none
module otit_host (
	input  wire logic        sys_clk,
	input  wire logic [7:0]  host_data_out,
	output logic             host_cs_n,
	output logic             host_as_n,
	output logic             host_write,
	output logic      [12:0] host_address,
	output logic      [7:0]  host_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// idle bus at time zero, data line not parked on a real value
	initial begin
		host_cs_n    = 1'b1;
		host_as_n    = 1'b1;
		host_write   = 1'b0;
		host_address = 13'h0000;
		host_data_in = 8'h5a;
	end
	// access held through its taking edge; answer sampled at the next falling edge
	task automatic access(input logic w, input logic [12:0] a, input logic [7:0] d,
	                      output logic [7:0] q);
		host_cs_n    = 1'b0;
		host_as_n    = 1'b0;
		host_write   = w;
		host_address = a;
		host_data_in = w ? d : ~host_data_in;
		@(negedge sys_clk);
		q = host_data_out;
	endtask : access
	// released data line toggles so no stale value looks valid
	task automatic idle();
		host_cs_n    = 1'b1;
		host_as_n    = 1'b1;
		host_write   = 1'b0;
		host_data_in = ~host_data_in;
		@(negedge sys_clk);
	endtask : idle
endmodule : otit_host
`default_nettype wire

// ---- tb/tb.sv ----
/* self-checking bench for otit_tree with the host model.
   assumes the monitor is bound from its own file. */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, reset_n, cs_n, as_n, wr, oe_n, irq_n, onesec;
	logic [12:0] addr;
	logic [7:0]  din, dout, fr_n, q;
	logic [63:0] txe, rxe;
	int          err_count, tests_run, cycles;

	otit_tree DUT (.sys_clk(sys_clk), .reset_n(reset_n), .host_cs_n(cs_n), .host_as_n(as_n),
		.host_write(wr), .host_address(addr), .host_data_in(din), .host_data_out(dout),
		.host_data_oe_n(oe_n), .host_irq_n(irq_n), .tx_cell_events(txe),
		.rx_cell_events(rxe), .framer_irq_in_n(fr_n), .one_second_event(onesec));
	otit_host host (.sys_clk(sys_clk), .host_data_out(dout), .host_cs_n(cs_n),
		.host_as_n(as_n), .host_write(wr), .host_address(addr), .host_data_in(din));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rd(input logic [12:0] a, input logic [7:0] exp, input string what);
		host.access(1'b0, a, 8'h00, q);
		host.idle();
		check(q, exp, what);
	endtask : rd
	task automatic wrt(input logic [12:0] a, input logic [7:0] d);
		host.access(1'b1, a, d, q);
		host.idle();
	endtask : wrt
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_and_readback();
		rd(13'h0202, 8'h00, "mode reset");
		rd(13'h0201, 8'h00, "enable reset");
		wrt(13'h0202, 8'h08); // only the pin enable bit set
		wrt(13'h0201, 8'hff);
		rd(13'h0202, 8'h08, "mode");
		for (int p = 0; p < 8; p++) begin
			wrt({4'h0, 3'(p), otit_pkg::OFF_SUM_MASK}, 8'h0f);
			wrt({4'h0, 3'(p), otit_pkg::OFF_TX_ENABLE}, 8'hff);
			wrt({4'h0, 3'(p), otit_pkg::OFF_RX_ENABLE}, 8'hff);
			rd({4'h0, 3'(p), otit_pkg::OFF_SUM_MASK}, 8'h0f, "mask");
			rd({4'h0, 3'(p), otit_pkg::OFF_TX_ENABLE}, 8'hff, "tx enable");
			rd({4'h0, 3'(p), otit_pkg::OFF_RX_ENABLE}, 8'hff, "rx enable");
		end
	endtask : t_reset_and_readback
	// top-down service, two flags per read except on port 7
	// two flags at once (one on port 7), traced top-down and cleared
	task automatic t_cell(input int p, input logic tx);
		logic [7:0] pat;
		pat = 8'h80 | (8'h01 << p);
		if (tx) txe[8*p +: 8] = pat;
		else rxe[8*p +: 8] = pat;
		@(negedge sys_clk);
		txe = 64'h0;
		rxe = 64'h0;
		repeat (2) @(negedge sys_clk);
		check({7'h00, irq_n}, 8'h00, "irq raised");
		rd(13'h0200, 8'h01 << p, "port status");
		rd({4'h0, 3'(p), 6'h00}, tx ? 8'h02 : 8'h01, "summary");
		rd({4'h0, 3'(p), 6'h00}, tx ? 8'h02 : 8'h01, "summary kept");
		host.access(1'b0, {4'h0, 3'(p), tx ? otit_pkg::OFF_TX_FLAGS : otit_pkg::OFF_RX_FLAGS},
			8'h00, q);
		check(q, pat, "flags");
		host.access(1'b0, addr, 8'h00, q);
		host.idle();
		check(q, 8'h00, "flags cleared");
		rd({4'h0, 3'(p), 6'h00}, 8'h00, "summary clear");
		rd(13'h0200, 8'h00, "port clear");
		check({7'h00, irq_n}, 8'h01, "irq dropped");
	endtask : t_cell
	// framer and one-second bits stay after their inputs go idle
	task automatic t_slow();
		onesec = 1'b1;
		fr_n = 8'hde;
		@(negedge sys_clk);
		onesec = 1'b0;
		fr_n = 8'hff;
		for (int p = 0; p < 8; p++) begin
			rd({4'h0, 3'(p), 6'h00}, (p == 0 || p == 5) ? 8'h0c : 8'h08, "slow bits");
			rd({4'h0, 3'(p), 6'h00}, 8'h00, "slow cleared");
		end
		rd(13'h0200, 8'h00, "port status idle");
	endtask : t_slow
	task automatic t_gates();
		wrt(13'h0201, 8'hfe);
		txe[0] = 1'b1;
		@(negedge sys_clk);
		txe[0] = 1'b0;
		repeat (2) @(negedge sys_clk);
		check({7'h00, irq_n}, 8'h01, "port masked");
		rd(13'h0200, 8'h01, "status unmasked");
		wrt(13'h0201, 8'hff);
		check({7'h00, irq_n}, 8'h00, "port unmasked");
		wrt(13'h0202, 8'h00);
		check({7'h00, irq_n}, 8'h01, "pin disabled");
		wrt(13'h0202, 8'h08);
		wrt(13'h0001, 8'h01);
		rd(13'h0200, 8'h00, "summary masked");
		wrt(13'h0001, 8'h0f);
		wrt(13'h0028, 8'hfe);
		rd(13'h0000, 8'h00, "cell masked");
		wrt(13'h0028, 8'hff);
		rd(13'h002c, 8'h01, "masked flag kept");
		rd(13'h0203, 8'h00, "reserved");
		rd(13'h1000, 8'h00, "framer window");
	endtask : t_gates
	// ----------------------------------------
	// clock, timeout, main sequence
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// a hang is cut short well past the expected few hundred cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end
	initial begin
		reset_n = 1'b0;
		txe = 64'h0;
		rxe = 64'h0;
		fr_n = 8'hff;
		onesec = 1'b0;
		repeat (20) @(negedge sys_clk);
		reset_n = 1'b1;
		t_reset_and_readback();
		for (int p = 0; p < 8; p++) begin
			t_cell(p, 1'b1);
			t_cell(p, 1'b0);
		end
		t_slow();
		t_gates();
		results();
	end
endmodule : tb
`default_nettype wire
